// ===== common/dmd_map.svh
`ifndef DMD_MAP_SVH
`define DMD_MAP_SVH

// ****************************************
// register map (byte addresses)
// ****************************************
`define DMD_AXI_AW 4
`define DMD_OFF_CTRL 4'h0
`define DMD_OFF_STATUS 4'h4
`define DMD_OFF_REGS 4'h8
`define DMD_OFF_RAMADDR 4'hC
`define DMD_CTRL_RUN 0
`define DMD_CTRL_RST 1'h1
`define DMD_RESP_OKAY 2'h0
`define DMD_RESP_SLVERR 2'h2

// ****************************************
// instruction word fields
// ****************************************
`define DMD_OPC_HI 15
`define DMD_OPC_LO 8
`define DMD_OPR_HI 7
`define DMD_OPR_LO 0
`define DMD_OP_NOOP 3'h0
`define DMD_OP_TO_RAM 3'h1
`define DMD_OP_TO_REG 3'h2
`define DMD_OP_ADD 3'h3
`define DMD_OP_OR 3'h4
`define DMD_OP_XOR 3'h5
`define DMD_OP_ADC 3'h6
`define DMD_OP_AND 3'h7
`define DMD_STEP_HOLD 2'h0
`define DMD_STEP_INC 2'h1
`define DMD_STEP_DEC 2'h2
`define DMD_STEP_REG 2'h3
`define DMD_PAT_IMM 4'hE
`define DMD_PAT_BR8 5'h1B
`define DMD_PAT_MASK 3'h4
`define DMD_PAT_UB 7'h44
`define DMD_PAT_LDAUX 7'h46
`define DMD_PAT_CTRL1 8'hEC
`define DMD_PAT_CTRL2 8'hFC
`define DMD_MK_EQ 2'h0
`define DMD_MK_NE 2'h1
`define DMD_MK_TRUE 2'h2
`define DMD_MK_FALSE 2'h3

// ****************************************
// control operand bits
// ****************************************
`define DMD_C1_READ 0
`define DMD_C1_WRITE 1
`define DMD_C1_BUSY 2
`define DMD_C1_HDIR 4
`define DMD_C1_CRC 5
`define DMD_C1_STEP 6
`define DMD_C1_LOAD 7
`define DMD_C2_DRV3 0
`define DMD_C2_DRV2 1
`define DMD_C2_DRV1 2
`define DMD_C2_INOP 3
`define DMD_C2_STROBE 4
`define DMD_C2_DELAY 5

// ****************************************
// timing
// ****************************************
`define DMD_DELAY_MS 10
`define DMD_CLK_KHZ 50000

`endif

// ===== common/dmd_pkg.sv
package dmd_pkg;
    typedef enum logic [1:0] {
        DMD_S_RUN = 2'b00,
        DMD_S_WRITE = 2'b01,
        DMD_S_DELAY = 2'b10
    } dmd_state_e;
    typedef logic [7:0] dmd_byte_t;
    typedef logic [8:0] dmd_addr_t;
endpackage

// ===== logic/dmd_decode.sv
// Functional notes
// [RL1] high byte is operation code, low byte is operand
// [RL2] bits 15-12 pick noop, to-RAM, to-register, add, OR, XOR, add-carry, AND
// [RL3] bits 9-8 pick first, second general register or status zero, one
// [RL4] step 00 stores to current RAM location, address unchanged
// [RL5] step 01 stores then increments, step 10 stores then decrements
// [RL6] step 11 writes register then increments; ALU operations only
// [RL7] register instructions ignore operand; 1700 stores status one, increments
// [RL8] immediates OR, XOR, add-carry register with operand into register; the code also ANDs register with operand for opcodes F8-FB
// [RL9] eight-bit branches test register zero or nonzero, target whole operand
// [RL10] mask branch: mask operand 7-4, target 3-0; true, false, equal, not-equal
// [RL11] nibble-select 0 compares register bits 3-0, 1 compares bits 7-4
// [RL12] unconditional branches load operand into low or high program page
// [RL13] RAM preset loads operand into data or work buffer half
// [RL14] control one: bit0 read gate, bit1 write gate, bit2 host busy
// [RL15] control one: bit4 direction, bit5 CRC preset, bit6 step, bit7 load
// [RL16] control two bits 0,1,2 select drive three, two, one
// [RL17] control two bit3 clears drive inoperable, bit4 strobes host
// [RL18] control two bit5 starts 10 ms delay; bits 6,7 unused
// [RL19] no-op only advances program address
// [RL20] true-match needs ones under mask ones; false-match zeros there
// [RL21] taken mask branch replaces address bits 3-0 only; else next step
// [RL22] adds update carry; add-with-carry uses it, plain add does not
// [RL23] unlisted opcodes behave as no-op
// [RL24] control outputs last one instruction cycle per execution
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "dmd_map.svh"

module dmd_decode #(
    parameter int DELAY_CYCLES = `DMD_DELAY_MS * `DMD_CLK_KHZ,
    parameter int DLY_W = 20
) (
    input logic clk,
    input logic rst_n,
    input logic ce,
    input logic [15:0] rom_data,
    output logic [8:0] rom_addr,
    input dmd_pkg::dmd_byte_t ram_rdata,
    output logic [8:0] ram_addr,
    output logic [8:0] ram_waddr,
    output logic [7:0] ram_wdata,
    output logic ram_we,
    output logic read_gate,
    output logic write_gate,
    output logic host_busy_out,
    output logic head_direction,
    output logic crc_preset,
    output logic head_step_pulse,
    output logic head_load,
    output logic drive_sel_three,
    output logic drive_sel_two,
    output logic drive_sel_one,
    output logic drive_inop_clear,
    output logic host_strobe,
    output logic delay_busy,
    input logic [3:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [3:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready
);
    import dmd_pkg::*;

    generate
        if (DELAY_CYCLES < 1 || DELAY_CYCLES >= (2 ** DLY_W)) begin : g_chk
            $error("delay count does not fit its counter");
        end
    endgenerate

    // ****************************************
    // functions
    // ****************************************
    function automatic logic [8:0] alu_f(input logic [2:0] op, input dmd_byte_t a,
                                         input dmd_byte_t b, input logic cin);
        logic [8:0] y;
        y = {1'b0, a};
        case (op)
            `DMD_OP_ADD: y = {1'b0, a} + {1'b0, b}; // RL22
            `DMD_OP_ADC: y = {1'b0, a} + {1'b0, b} + {8'h00, cin}; // RL22
            `DMD_OP_OR: y = {1'b0, a | b};
            `DMD_OP_XOR: y = {1'b0, a ^ b};
            `DMD_OP_AND: y = {1'b0, a & b};
            default: y = {1'b0, a};
        endcase
        return y;
    endfunction

    function automatic logic is_word(input logic [3:0] addr, input logic [3:0] off);
        return addr[3:2] == off[3:2];
    endfunction

    // ****************************************
    // state
    // ****************************************
    dmd_state_e state_r;
    dmd_addr_t pc_r, ram_addr_r, ram_waddr_r;
    dmd_byte_t ram_wdata_r, ctl1_r, ctl2_r;
    dmd_byte_t gpr_r [0:3];
    logic carry_r, ram_we_r, run_r, delay_busy_r;
    logic [DLY_W-1:0] dly_cnt_r;

    // ****************************************
    // decode
    // ****************************************
    wire [7:0] opc = rom_data[`DMD_OPC_HI:`DMD_OPC_LO]; // RL1
    wire [7:0] opr = rom_data[`DMD_OPR_HI:`DMD_OPR_LO]; // RL1
    wire [2:0] reg_op = opc[6:4]; // RL2
    wire [1:0] step = opc[3:2];
    wire [1:0] sel = opc[1:0]; // RL3
    wire is_reg = ~opc[7];
    wire is_alu = is_reg & (reg_op >= `DMD_OP_ADD);
    wire step_reg = step == `DMD_STEP_REG;
    wire is_imm = {opc[7:6], opc[3:2]} == `DMD_PAT_IMM; // RL8
    wire is_br8 = {opc[7:5], opc[3:2]} == `DMD_PAT_BR8; // RL9
    wire is_mask = {opc[7:6], opc[3]} == `DMD_PAT_MASK; // RL10
    wire is_ub = opc[7:1] == `DMD_PAT_UB; // RL12
    wire is_ldaux = opc[7:1] == `DMD_PAT_LDAUX; // RL13
    wire is_ctl1 = opc == `DMD_PAT_CTRL1; // RL14
    wire is_ctl2 = opc == `DMD_PAT_CTRL2; // RL16
    wire exec = ce & run_r & (state_r == DMD_S_RUN);

    wire [7:0] sel_val = gpr_r[sel]; // RL3
    wire [2:0] alu_op = is_imm ? {1'b1, opc[5:4]} : reg_op; // RL8
    wire [7:0] alu_b = is_imm ? opr : ram_rdata; // RL7
    wire [8:0] alu_out = alu_f(alu_op, sel_val, alu_b, carry_r);
    wire upd_carry = (is_alu | is_imm) & ((alu_op == `DMD_OP_ADD) | (alu_op == `DMD_OP_ADC)); // RL22

    // register and RAM destinations; step 11 is only legal for ALU ops
    wire to_reg_ok = is_reg & (reg_op == `DMD_OP_TO_REG) & ~step_reg; // RL6
    wire wr_reg = is_imm | to_reg_ok | (is_alu & step_reg); // RL6 RL8
    wire [7:0] reg_wdata = to_reg_ok ? ram_rdata : alu_out[7:0];
    wire to_ram_ok = is_reg & (reg_op == `DMD_OP_TO_RAM) & ~step_reg; // RL7
    wire wr_ram = to_ram_ok | (is_alu & ~step_reg); // RL4 RL5
    wire [7:0] ram_wr_val = to_ram_ok ? sel_val : alu_out[7:0];
    wire do_step = to_ram_ok | to_reg_ok | is_alu; // RL23
    wire [8:0] ram_inc = ram_addr_r + 9'h001;
    wire [8:0] ram_dec = ram_addr_r - 9'h001;
    wire [8:0] ram_nxt = is_ldaux ? {opc[0], opr} : // RL13
        ~do_step ? ram_addr_r :
        (step == `DMD_STEP_DEC) ? ram_dec : // RL5
        (step == `DMD_STEP_HOLD) ? ram_addr_r : ram_inc; // RL4 RL5 RL6

    // branch conditions
    wire [3:0] nib = opc[2] ? sel_val[7:4] : sel_val[3:0]; // RL11
    wire [3:0] mask = opr[7:4]; // RL10
    wire mk_true = (nib & mask) == mask; // RL20
    wire mk_false = (~nib & mask) == mask; // RL20
    wire mk_hit = (opc[5:4] == `DMD_MK_EQ) ? (nib == mask) :
        (opc[5:4] == `DMD_MK_NE) ? (nib != mask) :
        (opc[5:4] == `DMD_MK_TRUE) ? mk_true : mk_false; // RL10
    wire br8_hit = opc[4] ? (sel_val != 8'h00) : (sel_val == 8'h00); // RL9
    wire [8:0] pc_inc = pc_r + 9'h001;
    wire [8:0] pc_nxt = is_ub ? {opc[0], opr} : // RL12
        (is_br8 & br8_hit) ? {pc_r[8], opr} : // RL9
        (is_mask & mk_hit) ? {pc_r[8:4], opr[3:0]} : pc_inc; // RL21 RL19

    wire [7:0] ctl1_nxt = is_ctl1 ? opr : 8'h00; // RL14 RL15
    wire [7:0] ctl2_nxt = is_ctl2 ? opr : 8'h00; // RL16 RL17
    wire start_dly = is_ctl2 & opr[`DMD_C2_DELAY]; // RL18

    // ****************************************
    // sequencer
    // ****************************************
    // a RAM write takes its own cycle so the next read never sees stale data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= DMD_S_RUN;
            pc_r <= 9'h000;
            ram_addr_r <= 9'h000;
            ram_waddr_r <= 9'h000;
            ram_wdata_r <= 8'h00;
            ram_we_r <= 1'b0;
            carry_r <= 1'b0;
            ctl1_r <= 8'h00;
            ctl2_r <= 8'h00;
            dly_cnt_r <= '0;
            delay_busy_r <= 1'b0;
        end else if (ce) begin
            ctl1_r <= exec ? ctl1_nxt : 8'h00; // RL24
            ctl2_r <= exec ? ctl2_nxt : 8'h00; // RL24
            ram_we_r <= exec & wr_ram;
            unique case (state_r)
                DMD_S_RUN: begin
                    if (exec) begin
                        pc_r <= pc_nxt;
                        ram_addr_r <= ram_nxt;
                        ram_waddr_r <= ram_addr_r; // RL4
                        ram_wdata_r <= ram_wr_val;
                        if (upd_carry) begin
                            carry_r <= alu_out[8]; // RL22
                        end
                        if (start_dly) begin
                            dly_cnt_r <= DLY_W'(DELAY_CYCLES - 1); // RL18
                            state_r <= DMD_S_DELAY;
                            delay_busy_r <= 1'b1; // RL18
                        end else if (wr_ram) begin
                            state_r <= DMD_S_WRITE;
                        end
                    end
                end
                DMD_S_WRITE: begin
                    state_r <= DMD_S_RUN;
                end
                DMD_S_DELAY: begin
                    if (dly_cnt_r == '0) begin
                        state_r <= DMD_S_RUN;
                        delay_busy_r <= 1'b0;
                    end else begin
                        dly_cnt_r <= dly_cnt_r - 1'b1; // RL18
                    end
                end
                // code 11 is unused; fall back to running
                default: begin
                    state_r <= DMD_S_RUN;
                    delay_busy_r <= 1'b0;
                end
            endcase
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_gpr
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    gpr_r[gi] <= 8'h00;
                end else if (ce & exec & wr_reg & (sel == 2'(gi))) begin
                    gpr_r[gi] <= reg_wdata; // RL3 RL6 RL8
                end
            end
        end
    endgenerate

    // ****************************************
    // axi4-lite slave
    // ****************************************
    logic aw_hold_r, w_hold_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [3:0] awaddr_r;
    logic [31:0] wdata_r, rdata_r;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r;
    wire do_wr = aw_hold_r & w_hold_r & ~bvalid_r;
    wire wr_ctrl = do_wr & is_word(awaddr_r, `DMD_OFF_CTRL) & wstrb_r[0];
    wire wr_ok = is_word(awaddr_r, `DMD_OFF_CTRL);
    wire rd_ctrl = is_word(s_axi_araddr, `DMD_OFF_CTRL);
    wire rd_stat = is_word(s_axi_araddr, `DMD_OFF_STATUS);
    wire rd_regs = is_word(s_axi_araddr, `DMD_OFF_REGS);
    wire rd_ram = is_word(s_axi_araddr, `DMD_OFF_RAMADDR);
    wire [31:0] rd_mux = rd_ctrl ? {31'h0, run_r} :
        rd_stat ? {20'h0, state_r, carry_r, pc_r} :
        rd_regs ? {gpr_r[3], gpr_r[2], gpr_r[1], gpr_r[0]} :
        rd_ram ? {23'h0, ram_addr_r} : 32'h0;
    wire rd_ok = rd_ctrl | rd_stat | rd_regs | rd_ram;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= `DMD_RESP_OKAY;
            awaddr_r <= 4'h0;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            run_r <= `DMD_CTRL_RST;
        end else if (ce) begin
            if (s_axi_awvalid & awready_r) begin
                aw_hold_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
                awready_r <= 1'b0;
            end
            if (s_axi_wvalid & wready_r) begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                wready_r <= 1'b0;
            end
            if (do_wr) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? `DMD_RESP_OKAY : `DMD_RESP_SLVERR;
            end
            if (wr_ctrl) begin
                run_r <= wdata_r[`DMD_CTRL_RUN];
            end
            if (bvalid_r & s_axi_bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= `DMD_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid & arready_r) begin
                arready_r <= 1'b0;
                rvalid_r <= 1'b1;
                rdata_r <= rd_mux;
                rresp_r <= rd_ok ? `DMD_RESP_OKAY : `DMD_RESP_SLVERR;
            end else if (rvalid_r & s_axi_rready) begin
                rvalid_r <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign rom_addr = pc_r;
    assign ram_addr = ram_addr_r;
    assign ram_waddr = ram_waddr_r;
    assign ram_wdata = ram_wdata_r;
    assign ram_we = ram_we_r;
    assign read_gate = ctl1_r[`DMD_C1_READ]; // RL14
    assign write_gate = ctl1_r[`DMD_C1_WRITE]; // RL14
    assign host_busy_out = ctl1_r[`DMD_C1_BUSY]; // RL14
    assign head_direction = ctl1_r[`DMD_C1_HDIR]; // RL15
    assign crc_preset = ctl1_r[`DMD_C1_CRC]; // RL15
    assign head_step_pulse = ctl1_r[`DMD_C1_STEP]; // RL15
    assign head_load = ctl1_r[`DMD_C1_LOAD]; // RL15
    assign drive_sel_three = ctl2_r[`DMD_C2_DRV3]; // RL16
    assign drive_sel_two = ctl2_r[`DMD_C2_DRV2]; // RL16
    assign drive_sel_one = ctl2_r[`DMD_C2_DRV1]; // RL16
    assign drive_inop_clear = ctl2_r[`DMD_C2_INOP]; // RL17
    assign host_strobe = ctl2_r[`DMD_C2_STROBE]; // RL17
    assign delay_busy = delay_busy_r;
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
endmodule

// ===== sim/dmd_decode_sva.sv
`timescale 1ns/1ps
module dmd_decode_chk #(
    parameter int DELAY_CYCLES = 8
) (
    input logic clk,
    input logic rst_n,
    input logic ce,
    input logic [15:0] rom_data,
    input logic [8:0] rom_addr,
    input logic [8:0] ram_addr,
    input logic [8:0] ram_waddr,
    input logic ram_we,
    input logic read_gate,
    input logic host_strobe,
    input logic delay_busy
);
    logic [7:0] dly_cnt_r;
    // an instruction runs only outside the write and delay stalls
    wire exec = ce && !ram_we && !delay_busy;
    wire [7:0] opc = rom_data[15:8];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            dly_cnt_r <= 8'h00;
        else
            dly_cnt_r <= delay_busy ? dly_cnt_r + 8'h01 : 8'h00;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_step_hold: assert property (exec && rom_data[15:14] == 2'b00 && rom_data[11:10] == 2'b00 |=>
        ram_addr == $past(ram_addr)) else $error("ram address moved on step 00");
    a_store_inc: assert property (exec && opc[7:2] == 6'h05 |=> ram_we && ram_waddr == $past(ram_addr)
        && ram_addr == 9'($past(ram_addr) + 9'h001)) else $error("store then increment wrong");
    a_ctl_one: assert property ($rose(read_gate) |-> $past(opc) == 8'hEC && $past(rom_data[0]))
        else $error("read gate without control one");
    a_strobe_host: assert property (host_strobe |-> $past(opc) == 8'hFC && $past(rom_data[4]) ##1 !host_strobe)
        else $error("host strobe wrong");
    a_delay_len: assert property ($fell(delay_busy) |-> int'(dly_cnt_r) == DELAY_CYCLES)
        else $error("delay length wrong");
    a_delay_hold: assert property (delay_busy && $past(delay_busy) |-> $stable(rom_addr))
        else $error("program moved during delay");
    a_noop_next: assert property (exec && opc == 8'h00 |=> rom_addr == 9'($past(rom_addr) + 9'h001) && !ram_we)
        else $error("noop did more than step");
    a_ub_load: assert property (exec && opc[7:1] == 7'h44 |=> rom_addr == $past(rom_data[8:0]))
        else $error("unconditional branch target wrong");
    a_aux_load: assert property (exec && opc[7:1] == 7'h46 |=> ram_addr == $past(rom_data[8:0]))
        else $error("ram preset wrong");
    a_mask_nibble: assert property (exec && opc[7:6] == 2'b10 && !opc[3] |=>
        rom_addr == {$past(rom_addr[8:4]), $past(rom_data[3:0])} || rom_addr == 9'($past(rom_addr) + 9'h001))
        else $error("mask branch address wrong");
    cover property (ram_we);
    cover property ($rose(delay_busy));
    cover property (host_strobe);
endmodule
bind dmd_decode dmd_decode_chk #(.DELAY_CYCLES(DELAY_CYCLES)) u_chk (.clk, .rst_n, .ce, .rom_data, .rom_addr,
    .ram_addr, .ram_waddr, .ram_we, .read_gate, .host_strobe, .delay_busy);

// ===== sim/dmd_far_model.sv
`timescale 1ns/1ps
// ****
// microprogram rom and async-read working ram
// ****
module dmd_far_model (
    input logic clk,
    input logic [8:0] rom_addr,
    output logic [15:0] rom_data,
    input logic [8:0] ram_addr,
    output logic [7:0] ram_rdata,
    input logic [8:0] ram_waddr,
    input logic [7:0] ram_wdata,
    input logic ram_we
);
    logic [15:0] rom [512];
    logic [7:0] ram [512];
    // unused steps hold a control strobe, so a wrong jump shows up as an event
    initial begin
        for (int i = 0; i < 512; i++) begin
            rom[i] = 16'hEC01;
            ram[i] = 8'h00;
        end
    end
    assign rom_data = rom[rom_addr];
    assign ram_rdata = ram[ram_addr];
    always @(posedge clk) begin
        if (ram_we === 1'b1)
            ram[ram_waddr] <= ram_wdata;
    end
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst_n, ce, ram_we, read_gate, write_gate, host_busy_out, head_direction, crc_preset, head_step_pulse;
    logic head_load, drive_sel_three, drive_sel_two, drive_sel_one, drive_inop_clear, host_strobe, delay_busy;
    logic [15:0] rom_data;
    logic [15:0] prog [29];
    logic [8:0] rom_addr, ram_addr, ram_waddr;
    logic [7:0] ram_rdata, ram_wdata, rnd;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [20:0] exp_q [$];
    int n_errors, n_tests, n;
    wire [11:0] stb = {read_gate, write_gate, host_busy_out, head_direction, crc_preset, head_step_pulse,
        head_load, drive_sel_three, drive_sel_two, drive_sel_one, drive_inop_clear, host_strobe};
    always #10 clk = ~clk;
    dmd_decode #(.DELAY_CYCLES(8)) DUT (.clk, .rst_n, .ce, .rom_data, .rom_addr, .ram_rdata, .ram_addr,
        .ram_waddr, .ram_wdata, .ram_we, .read_gate, .write_gate, .host_busy_out, .head_direction, .crc_preset,
        .head_step_pulse, .head_load, .drive_sel_three, .drive_sel_two, .drive_sel_one, .drive_inop_clear,
        .host_strobe, .delay_busy, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    dmd_far_model far (.clk, .rom_addr, .rom_data, .ram_addr, .ram_rdata, .ram_waddr, .ram_wdata, .ram_we);
    // ****
    // checking helpers
    // ****
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    task automatic print_verdict;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic fail(input string m);
        n_errors++;
        $display("MISMATCH %0t %s", $time, m);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] e, input string m);
        n_tests++;
        if (got !== e)
            fail(m);
    endtask
    task automatic tick(inout int k);
        @(posedge clk);
        k++;
        if (k > 400) begin
            fail("wait ran out");
            print_verdict;
        end
    endtask
    task automatic pop(input logic [20:0] got);
        n_tests++;
        if (exp_q.size() == 0)
            fail("unexpected event");
        else if (exp_q.pop_front() !== got)
            fail("event differs");
    endtask
    // ****
    // axi-lite master, one transfer at a time
    // ****
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        int k;
        logic aw, w;
        k = 0;
        aw = 1'b1;
        w = 1'b1;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            tick(k);
            if (aw && s_axi_awready) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end while (aw || w || !s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, 32'h0, "write response");
    endtask
    task automatic axi_rd(input logic [3:0] a, input logic [31:0] e, input string m);
        int k;
        k = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            tick(k);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e, m);
    endtask
    // ram writes and strobes are taken off the queue in order of appearance
    always @(posedge clk) begin
        if (rst_n === 1'b1 && ram_we === 1'b1)
            pop({4'h0, ram_waddr, ram_wdata});
        if (rst_n === 1'b1 && stb !== 12'h000)
            pop({9'h100, stb});
    end
    // ****
    // main sequence
    // ****
    initial begin
        {n_errors, n_tests, n} = 0;
        {rst_n, s_axi_awaddr, s_axi_araddr, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
        {s_axi_arvalid, s_axi_rready, s_axi_wdata} = 0;
        ce = 1'b1;
        s_axi_wstrb = 4'hF;
        seed = xs(32'd54247);
        rnd = seed[7:0];
        prog = '{16'h2000, 16'h2100, 16'h2200, 16'hC8A5, 16'hD8FF, 16'hC93C, 16'h8C10, 16'h1400, 16'h1900,
            16'h3C00, 16'hE8F0, 16'h6D00, 16'h804F, 16'hEC01, 16'hEC01, 16'h94A0, 16'hA195, 16'hEC01,
            16'hEC01, 16'hEC01, 16'hEC01, 16'hB18D, 16'hECF7, 16'hFC3F, 16'h8D20, 16'h2700, 16'h1700,
            16'h0000, 16'h8940};
        #1;
        for (int i = 0; i < 29; i++)
            far.rom[i] = prog[i];
        far.rom[9'h140] = 16'h8940;
        far.ram[9'h120] = rnd;
        exp_q.push_back({4'h0, 9'h010, 8'h5A});
        exp_q.push_back({4'h0, 9'h011, 8'h3C});
        exp_q.push_back({9'h100, 12'hFE0});
        exp_q.push_back({9'h100, 12'h01F});
        exp_q.push_back({4'h0, 9'h121, rnd});
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        while (rom_addr !== 9'h140)
            tick(n);
        repeat (4) @(posedge clk);
        chk(exp_q.size(), 32'h0, "events missing");
        axi_rd(4'h8, {rnd, 8'h00, 8'h79, 8'hA4}, "register values");
        axi_rd(4'h4, 32'h0000_0140, "program address");
        axi_rd(4'hC, 32'h0000_0122, "ram address");
        axi_rd(4'h0, 32'h0000_0001, "run after reset");
        axi_wr(4'h0, {seed[31:1], 1'b0});
        axi_rd(4'h0, 32'h0000_0000, "run cleared");
        print_verdict;
    end
endmodule
